// ===== src/correlator_output_serializer.sv
/*
  correlator output serializer: twin sample RAMs, lookup memories, beam, auto and cross
  engines, output FIFOs, fixed-order drain and a packet builder with a packet counter.
  assumes the upstream writer fills the sample RAMs and drops samp_we to start a pass,
  at most once per burst period, and that software keeps counts within 128.
*/
// Contract
// - software sets antenna count and correlation count; they set engine iterations.
// - engines start when the sample RAM write enable falls.
// - port A feeds cross engine; port B feeds beam and auto engines.
// - counters address lookup memories; returned indices address the sample RAMs.
// - beam accumulators cleared at least one cycle before first sample arrives.
// - accumulator adds only when strobe high; sum visible one cycle later.
// - beam sum requantized to 32-bit real and 32-bit imaginary word.
// - auto engines multiply sample by own conjugate, one for H, one for V.
// - each auto and cross result goes to a FIFO with empty flag.
// - cross engine multiplies A by conjugate of B, quantized to 64 bits.
// - engines run once per buffered spectrum set, one burst per 8192 cycles.
// - at most 128 autos and 128 crosses; configured counts must stay within.
// - FIFOs drained in order: auto H, auto V, then cross.
// - after cross, H beam then V beam, exactly 2 cycles.
// - sequencing state selects output stream; valid marks each data word.
// - auto and cross window lengths follow configured counts.
// - packet builder gets valid with each 64-bit word and a packet size.
// - 64-bit counter inserted cycle after end-of-packet; word there is lost.
// - packet size comes from a software-writable register.
// - simulation flag replaces samples with index-numbered ramps.
`timescale 1ns/100ps
`include "corr_serializer_params.svh"

module correlator_output_serializer
  import corr_serializer_pkg::*;
#(
  parameter int SW    = 18,
  parameter int DEPTH = 128
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [15:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [15:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              samp_we,
  input  wire logic [4:0]        samp_waddr,
  input  wire logic [2*SW-1:0]   samp_wdata,
  output logic [63:0]            tx_data,
  output logic                   tx_valid,
  output logic                   tx_eof,
  output logic [15:0]            tx_pkt_size
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [31:0] sat32(input logic signed [39:0] v);
    if (v > 40'sh007fffffff) return 32'h7fffffff;
    if (v < -40'sh0080000000) return 32'h80000000;
    return v[31:0];
  endfunction : sat32

  // ---------------------------------------------------------------------------
  // registers and AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic              sim_reg, sim_next;
  logic [7:0]        nant_reg, nant_next, nxc_reg, nxc_next;
  logic [15:0]       psize_reg, psize_next, lost_reg, lost_next;
  logic              aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [15:0]       awa_reg, awa_next;
  logic [31:0]       wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0]        br_reg, br_next, rr_reg, rr_next;
  logic [4:0]        lut [4][DEPTH];
  logic              do_wr, lut_we;
  logic [1:0]        lut_sel;
  logic [63:0]       pcnt_reg, pcnt_next;
  seq_state_t        st_reg, st_next;

  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready  = !w_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign tx_pkt_size   = psize_reg;
  assign do_wr   = aw_reg && w_reg && !bv_reg;
  assign lut_sel = 2'(awa_reg[11:9] - 3'h1);
  assign lut_we  = do_wr && awa_reg >= `LUT_POL_H_BASE && awa_reg < `LUT_B_BASE + `LUT_WIN_BYTES;

  always_comb begin
    aw_next = aw_reg;   w_next = w_reg;     awa_next = awa_reg;   wd_next = wd_reg;
    bv_next = bv_reg;   br_next = br_reg;   rv_next = rv_reg;     rd_next = rd_reg;
    rr_next = rr_reg;   sim_next = sim_reg; nant_next = nant_reg; nxc_next = nxc_reg;
    psize_next = psize_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (do_wr) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = `RESP_OKAY;
      unique case (awa_reg)
        `OFS_CTRL:      sim_next   = wd_reg[`CTRL_SIM_BIT];
        `OFS_NUM_ANT:   nant_next  = wd_reg[7:0];
        `OFS_NUM_XCORR: nxc_next   = wd_reg[7:0];
        `OFS_PKT_SIZE:  psize_next = wd_reg[15:0];
        default:        if (!lut_we) br_next = `RESP_SLVERR;
      endcase
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = `RESP_OKAY;
      rd_next = 32'h0;
      if (s_axi_araddr >= `LUT_POL_H_BASE && s_axi_araddr < `LUT_B_BASE + `LUT_WIN_BYTES) begin
        rd_next = {27'h0, lut[2'(s_axi_araddr[11:9] - 3'h1)][s_axi_araddr[8:2]]};
      end else begin
        unique case (s_axi_araddr)
          `OFS_CTRL:      rd_next = {31'h0, sim_reg};
          `OFS_NUM_ANT:   rd_next = {24'h0, nant_reg};
          `OFS_NUM_XCORR: rd_next = {24'h0, nxc_reg};
          `OFS_PKT_SIZE:  rd_next = {16'h0, psize_reg};
          `OFS_STATUS:    rd_next = {lost_reg, 13'h0, st_reg};
          `OFS_PKT_COUNT: rd_next = pcnt_reg[31:0];
          default:        rr_next = `RESP_SLVERR;
        endcase
      end
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_reg <= 1'b0;  w_reg <= 1'b0;  bv_reg <= 1'b0;  rv_reg <= 1'b0;
      awa_reg <= 16'h0;  wd_reg <= 32'h0;  rd_reg <= 32'h0;
      br_reg <= `RESP_OKAY;  rr_reg <= `RESP_OKAY;  sim_reg <= 1'b0;
      nant_reg <= `RST_NUM_ANT;  nxc_reg <= `RST_NUM_XCORR;  psize_reg <= `RST_PKT_SIZE;
    end else begin
      aw_reg <= aw_next;  w_reg <= w_next;  bv_reg <= bv_next;  rv_reg <= rv_next;
      awa_reg <= awa_next;  wd_reg <= wd_next;  rd_reg <= rd_next;
      br_reg <= br_next;  rr_reg <= rr_next;  sim_reg <= sim_next;
      nant_reg <= nant_next;  nxc_reg <= nxc_next;  psize_reg <= psize_next;
    end
  end

  // host-loaded lookup memories, read by the engines and over AXI4-Lite
  always_ff @(posedge clk) begin
    if (lut_we) begin
      lut[lut_sel][awa_reg[8:2]] <= wd_reg[4:0];
    end
  end

  // ---------------------------------------------------------------------------
  // twin sample RAMs
  // ---------------------------------------------------------------------------
  logic [2*SW-1:0] ram_x [32];
  logic [2*SW-1:0] ram_y [32];
  logic [2*SW-1:0] wr_word;
  logic            we_d_reg;

  // ramp test pattern: antenna k carries real part k, imaginary zero
  assign wr_word = sim_reg ? {SW'(samp_waddr), SW'(0)} : samp_wdata;

  always_ff @(posedge clk) begin
    if (samp_we) begin
      ram_x[samp_waddr] <= wr_word;
      ram_y[samp_waddr] <= wr_word;
    end
    we_d_reg <= reset ? 1'b0 : samp_we;
  end

  // ---------------------------------------------------------------------------
  // engine pipeline: lookup, RAM read, compute
  // ---------------------------------------------------------------------------
  logic [7:0]        na, nx, niter, idx_reg, idx_next;
  logic              start, p1a_reg, p1x_reg, p2a_reg, p2x_reg;
  logic [4:0]        ih_reg, iv_reg, ia_reg, ib_reg;
  logic [2*SW-1:0]   sh_reg, sv_reg, sa_reg, sb_reg;
  logic signed [SW-1:0] hr, hi, vr, vi, ar, ai, bre, bim;
  logic signed [SW+7:0] acch_r_reg, acch_i_reg, accv_r_reg, accv_i_reg;
  logic [63:0]       res [3];
  logic [2:0]        fwe, frd, fempty;
  logic [63:0]       fdata [3];

  assign start = we_d_reg && !samp_we;
  assign na    = (nant_reg > `MAX_PRODUCTS) ? `MAX_PRODUCTS : nant_reg;
  assign nx    = (nxc_reg > `MAX_PRODUCTS) ? `MAX_PRODUCTS : nxc_reg;
  assign niter = (na > nx) ? na : nx;
  assign {hr, hi} = sh_reg;
  assign {vr, vi} = sv_reg;
  assign {ar, ai} = sa_reg;
  assign {bre, bim} = sb_reg;

  always_comb begin
    st_next  = st_reg;
    idx_next = idx_reg;
    unique case (st_reg)
      SEQ_IDLE: if (start) begin
        st_next  = SEQ_RUN;
        idx_next = 8'h0;
      end
      SEQ_RUN: begin
        idx_next = 8'(idx_reg + 8'h1);
        if (idx_next >= niter) st_next = SEQ_FLUSH;
      end
      SEQ_FLUSH:  if (!p1a_reg && !p1x_reg && !p2a_reg && !p2x_reg) st_next = SEQ_AUTO_H;
      SEQ_AUTO_H: if (fempty[0]) st_next = SEQ_AUTO_V;
      SEQ_AUTO_V: if (fempty[1]) st_next = SEQ_CROSS;
      SEQ_CROSS:  if (fempty[2]) st_next = SEQ_BEAM_H;
      SEQ_BEAM_H: st_next = SEQ_BEAM_V;
      SEQ_BEAM_V: st_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg  <= SEQ_IDLE;
      idx_reg <= 8'h0;
      p1a_reg <= 1'b0;  p1x_reg <= 1'b0;  p2a_reg <= 1'b0;  p2x_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      idx_reg <= idx_next;
      p1a_reg <= (st_reg == SEQ_RUN) && (idx_reg < na);
      p1x_reg <= (st_reg == SEQ_RUN) && (idx_reg < nx);
      p2a_reg <= p1a_reg;
      p2x_reg <= p1x_reg;
    end
  end

  // counters index the lookup memories; their contents address the RAMs
  always_ff @(posedge clk) begin
    ih_reg <= lut[0][idx_reg[AW-1:0]];
    iv_reg <= lut[1][idx_reg[AW-1:0]];
    ia_reg <= lut[2][idx_reg[AW-1:0]];
    ib_reg <= lut[3][idx_reg[AW-1:0]];
    sa_reg <= ram_x[ia_reg];
    sb_reg <= ram_y[ib_reg];
    sh_reg <= ram_x[ih_reg];
    sv_reg <= ram_y[iv_reg];
  end

  // beam accumulators, cleared on the start cycle, two cycles ahead of data
  always_ff @(posedge clk) begin
    if (reset || start) begin
      acch_r_reg <= '0;  acch_i_reg <= '0;  accv_r_reg <= '0;  accv_i_reg <= '0;
    end else if (p2a_reg) begin
      acch_r_reg <= acch_r_reg + hr;
      acch_i_reg <= acch_i_reg + hi;
      accv_r_reg <= accv_r_reg + vr;
      accv_i_reg <= accv_i_reg + vi;
    end
  end

  // products: sample times own conjugate, and A times conjugate of B
  assign res[0] = {sat32(40'(hr * hr) + 40'(hi * hi)), 32'h0};
  assign res[1] = {sat32(40'(vr * vr) + 40'(vi * vi)), 32'h0};
  assign res[2] = {sat32(40'(ar * bre) + 40'(ai * bim)),
                   sat32(40'(ai * bre) - 40'(ar * bim))};
  assign fwe = {p2x_reg, p2a_reg, p2a_reg};
  assign frd = {(st_reg == SEQ_CROSS) && !fempty[2],
                (st_reg == SEQ_AUTO_V) && !fempty[1],
                (st_reg == SEQ_AUTO_H) && !fempty[0]};

  // ---------------------------------------------------------------------------
  // output FIFOs
  // ---------------------------------------------------------------------------
  for (genvar f = 0; f < 3; f++) begin : g_fifo
    logic [63:0] mem [DEPTH];
    logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
    assign fempty[f] = (wp_reg == rp_reg);
    assign fdata[f]  = mem[rp_reg[AW-1:0]];
    always_comb begin
      wp_next = fwe[f] ? AW'(1) + wp_reg : wp_reg;
      rp_next = frd[f] ? AW'(1) + rp_reg : rp_reg;
    end
    always_ff @(posedge clk) begin
      if (fwe[f]) mem[wp_reg[AW-1:0]] <= res[f];
      wp_reg <= reset ? '0 : wp_next;
      rp_reg <= reset ? '0 : rp_next;
    end
  end

  // ---------------------------------------------------------------------------
  // output multiplexer and packet builder
  // ---------------------------------------------------------------------------
  logic        sv_out_reg, sv_out_next, ins_reg, ins_next;
  logic [63:0] sd_reg, sd_next, td_reg, td_next;
  logic        tv_reg, tv_next, te_reg, te_next;
  logic [15:0] wc_reg, wc_next;

  assign tx_data  = td_reg;
  assign tx_valid = tv_reg;
  assign tx_eof   = te_reg;

  always_comb begin
    sv_out_next = 1'b1;
    unique case (st_reg)
      SEQ_AUTO_H: begin sd_next = fdata[0]; sv_out_next = frd[0]; end
      SEQ_AUTO_V: begin sd_next = fdata[1]; sv_out_next = frd[1]; end
      SEQ_CROSS:  begin sd_next = fdata[2]; sv_out_next = frd[2]; end
      SEQ_BEAM_H: sd_next = {32'(acch_r_reg), 32'(acch_i_reg)};
      SEQ_BEAM_V: sd_next = {32'(accv_r_reg), 32'(accv_i_reg)};
      default: begin sd_next = sd_reg; sv_out_next = 1'b0; end
    endcase
  end

  always_comb begin
    td_next = td_reg;  tv_next = 1'b0;  te_next = 1'b0;  ins_next = 1'b0;
    wc_next = wc_reg;  pcnt_next = pcnt_reg;  lost_next = lost_reg;
    if (ins_reg) begin
      td_next   = pcnt_reg;
      tv_next   = 1'b1;
      pcnt_next = pcnt_reg + 64'h1;
      if (sv_out_reg) lost_next = lost_reg + 16'h1;
    end else if (sv_out_reg) begin
      td_next = sd_reg;
      tv_next = 1'b1;
      if (psize_reg != 16'h0 && wc_reg == psize_reg - 16'h1) begin
        te_next  = 1'b1;
        ins_next = 1'b1;
        wc_next  = 16'h0;
      end else begin
        wc_next = wc_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sv_out_reg <= 1'b0;  sd_reg <= 64'h0;  td_reg <= 64'h0;  tv_reg <= 1'b0;
      te_reg <= 1'b0;  ins_reg <= 1'b0;  wc_reg <= 16'h0;  pcnt_reg <= 64'h0;
      lost_reg <= 16'h0;
    end else begin
      sv_out_reg <= sv_out_next;  sd_reg <= sd_next;  td_reg <= td_next;  tv_reg <= tv_next;
      te_reg <= te_next;  ins_reg <= ins_next;  wc_reg <= wc_next;  pcnt_reg <= pcnt_next;
      lost_reg <= lost_next;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  engine_start_a: assert property (st_reg == SEQ_IDLE && $fell(samp_we) |=> st_reg == SEQ_RUN)
    else $error("engines did not start on write enable fall");
  beam_clear_a: assert property (start |=> acch_r_reg == '0 && !p2a_reg)
    else $error("beam accumulator not cleared ahead of data");
  accum_hold_a: assert property (!p2a_reg && !start |=> $stable(acch_r_reg))
    else $error("accumulator moved without strobe");
  drain_order_a: assert property (st_reg == SEQ_AUTO_V |-> $past(st_reg) inside {SEQ_AUTO_H,
    SEQ_AUTO_V}) else $error("auto V drained out of order");
  beam_two_a: assert property (st_reg == SEQ_BEAM_H |=> st_reg == SEQ_BEAM_V ##1
    st_reg == SEQ_IDLE) else $error("beam window not two cycles");
  read_hold_a: assert property (st_reg == SEQ_CROSS && !fempty[2] |-> frd[2] ##1
    st_reg == SEQ_CROSS) else $error("cross read left before empty");
  counter_ins_a: assert property (te_reg |-> tv_reg ##1 (tv_reg && td_reg == $past(pcnt_reg)))
    else $error("packet counter not inserted after eof");
  counter_inc_a: assert property (ins_reg |=> pcnt_reg == $past(pcnt_reg) + 64'h1)
    else $error("packet counter did not step by one");
  window_len_a: assert property (st_reg == SEQ_RUN && idx_reg >= na |=> !p1a_reg)
    else $error("auto window exceeds antenna count");
  limit_a: assert property (st_reg == SEQ_RUN |-> idx_reg < `MAX_PRODUCTS)
    else $error("iteration count above limit");
endmodule : correlator_output_serializer

// ===== src/corr_serializer_params.svh
/*
  offsets, field positions, reset values and counts of the correlator output serializer.
  assumes an AXI4-Lite byte address of 16 bits.
*/
`ifndef CORR_SERIALIZER_PARAMS_SVH
`define CORR_SERIALIZER_PARAMS_SVH
// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define OFS_CTRL        16'h0000
`define OFS_NUM_ANT     16'h0004
`define OFS_NUM_XCORR   16'h0008
`define OFS_PKT_SIZE    16'h000c
`define OFS_STATUS      16'h0010
`define OFS_PKT_COUNT   16'h0014
`define LUT_POL_H_BASE  16'h0200
`define LUT_POL_V_BASE  16'h0400
`define LUT_A_BASE      16'h0600
`define LUT_B_BASE      16'h0800
`define LUT_WIN_BYTES   16'h0200
// ---------------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------------
`define CTRL_SIM_BIT    0
`define RST_NUM_ANT     8'h00
`define RST_NUM_XCORR   8'h00
`define RST_PKT_SIZE    16'h0000
`define MAX_PRODUCTS    8'h80
`define BEAM_WORDS      2
`define BURST_PERIOD    8192
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// ===== src/corr_serializer_pkg.sv
/*
  types of the correlator output serializer.
  assumes nothing of its surroundings.
*/
package corr_serializer_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE   = 3'b000,
    SEQ_RUN    = 3'b001,
    SEQ_FLUSH  = 3'b010,
    SEQ_AUTO_H = 3'b011,
    SEQ_AUTO_V = 3'b100,
    SEQ_CROSS  = 3'b101,
    SEQ_BEAM_H = 3'b110,
    SEQ_BEAM_V = 3'b111
  } seq_state_t;
endpackage : corr_serializer_pkg

// ===== sim/packet_sink.sv
/*
  packetizer-side model: records every valid word with its end-of-packet flag.
  assumes the serializer stream has no backpressure.
*/
`timescale 1ns/100ps
module packet_sink (
  input wire logic        clk,
  input wire logic [63:0] tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_eof
);
  logic [63:0] words[$];
  logic        eofs[$];
  // one word taken per valid cycle, eof kept beside it
  always @(posedge clk) begin
    if (tx_valid === 1'b1) begin
      words.push_back(tx_data);
      eofs.push_back(tx_eof);
    end
  end
endmodule : packet_sink

// ===== sim/tb_correlator_output_serializer.sv
/*
  testbench: loads counts and lookup memories over AXI4-Lite, writes samples, checks bursts.
  assumes the packet size equals one burst, so each burst is followed by one counter word,
  except in the closing short-packet case, where the counter overwrites the last beam word.
*/
`timescale 1ns/100ps
`include "corr_serializer_params.svh"
module tb_correlator_output_serializer;
  import corr_serializer_pkg::*;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready, samp_we;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_eof;
  logic [15:0] awaddr, araddr, tx_pkt_size;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  samp_waddr;
  logic [35:0] samp_wdata;
  logic [63:0] tx_data, rv, expq[$];
  int fails, comparisons, seed, na, nx, len, t, sr, si;
  int hl[16], vl[16], al[16], bl[16], re[32], im[32];

  correlator_output_serializer dut_u (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .samp_we(samp_we),
    .samp_waddr(samp_waddr), .samp_wdata(samp_wdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_eof(tx_eof), .tx_pkt_size(tx_pkt_size));
  packet_sink sink_u (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_eof(tx_eof));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // each channel held until its own ready is seen high at a rising edge
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'b11;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [63:0] d);
    logic done;
    done = 1'b0;
    d = '1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = {30'h0, rresp, rdata};
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask : axi_rd
  task automatic close_out;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  function automatic logic [63:0] cx(input int ar, ai, br, bi);
    return {32'(ar * br + ai * bi), 32'(ai * br - ar * bi)};
  endfunction : cx

  // ---------------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000 fails++;
    close_out();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, samp_we} = '0;
    awaddr = '0; araddr = '0; wdata = '0; samp_waddr = '0; samp_wdata = '0;
    reset = 1'b1; fails = 0; comparisons = 0; seed = 76037;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axi_rd(`OFS_NUM_ANT, rv); chk(rv, 64'h0);
    axi_rd(`OFS_PKT_SIZE, rv); chk(rv, 64'h0);
    axi_rd(16'h0100, rv); chk(rv, {30'h0, `RESP_SLVERR, 32'h0});
    axi_wr(16'h0100, 32'h1, rsp); chk(64'(rsp), 64'(`RESP_SLVERR));
    for (int b = 0; b < 4; b++) begin
      na = 1 + ($random(seed) & 15); nx = 1 + ($random(seed) & 15);
      if (b == 3) begin na = 16; nx = 16; end
      len = 2 * na + nx + `BEAM_WORDS;
      for (int i = 0; i < 16; i++) begin
        hl[i] = $random(seed) & 31; vl[i] = $random(seed) & 31;
        al[i] = $random(seed) & 31; bl[i] = $random(seed) & 31;
        axi_wr(`LUT_POL_H_BASE + 16'(4 * i), 32'(hl[i]), rsp);
        axi_wr(`LUT_POL_V_BASE + 16'(4 * i), 32'(vl[i]), rsp);
        axi_wr(`LUT_A_BASE + 16'(4 * i), 32'(al[i]), rsp);
        axi_wr(`LUT_B_BASE + 16'(4 * i), 32'(bl[i]), rsp);
      end
      axi_wr(`OFS_CTRL, 32'(b == 1), rsp);
      axi_wr(`OFS_NUM_ANT, 32'(na), rsp);
      axi_wr(`OFS_NUM_XCORR, 32'(nx), rsp);
      axi_wr(`OFS_PKT_SIZE, 32'(len), rsp);
      chk(64'(tx_pkt_size), 64'(len));
      for (int i = 0; i < 32; i++) begin
        re[i] = (b == 1) ? i : $random(seed) % 128;
        im[i] = (b == 1) ? 0 : $random(seed) % 128;
        samp_we <= 1'b1; samp_waddr <= 5'(i);
        samp_wdata <= (b == 1) ? 36'(~i) : {18'(re[i]), 18'(im[i])};
        @(posedge clk);
      end
      sink_u.words.delete(); sink_u.eofs.delete(); expq.delete();
      samp_we <= 1'b0;
      // expected burst: autos H, autos V, cross, beam H, beam V, counter
      for (int i = 0; i < na; i++) expq.push_back(cx(re[hl[i]], im[hl[i]], re[hl[i]], im[hl[i]]));
      for (int i = 0; i < na; i++) expq.push_back(cx(re[vl[i]], im[vl[i]], re[vl[i]], im[vl[i]]));
      for (int i = 0; i < nx; i++) expq.push_back(cx(re[al[i]], im[al[i]], re[bl[i]], im[bl[i]]));
      for (int p = 0; p < 2; p++) begin
        sr = 0; si = 0;
        for (int i = 0; i < na; i++) begin
          sr += re[p ? vl[i] : hl[i]]; si += im[p ? vl[i] : hl[i]];
        end
        expq.push_back({32'(sr), 32'(si)});
      end
      expq.push_back(64'(b));
      for (t = 0; t < 3000 && sink_u.words.size() < len + 1; t++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(64'(sink_u.words.size()), 64'(len + 1));
      for (int k = 0; k <= len; k++) begin
        chk(sink_u.words[k], expq[k]);
        chk(64'(sink_u.eofs[k]), 64'(k == len - 1));
      end
    end
    // packet one word short of the burst: the counter lands on the beam V word
    axi_wr(`OFS_PKT_SIZE, 32'(len - 1), rsp);
    sink_u.words.delete();
    sink_u.eofs.delete();
    samp_we <= 1'b1;
    samp_waddr <= 5'h0;
    samp_wdata <= {18'(re[0]), 18'(im[0])};
    @(posedge clk);
    samp_we <= 1'b0;
    for (t = 0; t < 3000 && sink_u.words.size() < len; t++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(64'(sink_u.words.size()), 64'(len));
    for (int k = 0; k < len - 1; k++) begin
      chk(sink_u.words[k], expq[k]);
    end
    chk(64'(sink_u.eofs[len - 2]), 64'h1);
    chk(sink_u.words[len - 1], 64'h4);
    axi_rd(`OFS_STATUS, rv); chk(rv, 64'h0001_0000);
    axi_rd(`OFS_PKT_COUNT, rv); chk(rv, 64'h5);
    close_out();
  end
endmodule : tb_correlator_output_serializer
